// ===== parcr_pkg.sv
// Constants and types shared by the pad and regulator configuration registers
package parcr_pkg;

  // ----------------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------------
  // Register offsets, word addresses on the register port
  // ----------------------------------------------------------------------
  localparam logic [15:0] OFS_SLEW    = 16'h1c16; // output_slew_select
  localparam logic [15:0] OFS_INHIBIT = 16'h1c17; // serial_pin_pulldown_inhibit
  localparam logic [15:0] OFS_REGCTL  = 16'h7004; // regulator_control

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_USB_EN    = 0;  // regulator_control
  localparam int BIT_VOLT_SEL  = 1;  // regulator_control
  localparam int BIT_CLK_SLEW  = 2;  // output_slew_select
  localparam int BIT_EMIF_SLEW = 0;  // output_slew_select
  localparam int SP_PINS       = 6;  // pins per serial port
  localparam int SP1_LSB       = 8;  // serial port 1 inhibit field
  localparam int SP0_LSB       = 0;  // serial port 0 inhibit field

  // ----------------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------------
  localparam logic       RST_USB_EN   = 1'h0;
  localparam logic       RST_VOLT_SEL = 1'h0;
  localparam logic       RST_SLEW     = 1'h1;
  localparam logic [5:0] RST_INHIBIT  = 6'h3f;
  localparam logic       VOLT_1P30    = 1'h0; // core regulator at 1.3 V
  localparam logic       VOLT_1P05    = 1'h1; // core regulator at 1.05 V
  localparam logic       SLEW_FAST    = 1'h1;
  localparam logic [15:0] DATA_ZERO   = 16'h0000;

  // ----------------------------------------------------------------------
  // Register state of the bank
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        usb_en;
    logic        volt_sel;
    logic        clk_slew;
    logic        emif_slew;
    logic [5:0]  sp1_inh;
    logic [5:0]  sp0_inh;
    logic [15:0] rdata;
  } parcr_state_t;

  // Two-stage synchroniser state
  typedef struct packed {
    logic meta;
    logic q;
  } parcr_sync_t;

endpackage : parcr_pkg

// ===== parcr_regs.sv
// Pad and regulator configuration register bank with regulator enable decode
//
// Behaviour
// [R1] Bits 15 to 2 of regulator_control read as zero and writes to them are dropped.
// [R2] regulator_control bit 1 picks the core regulator voltage, 0 for 1.3 V, 1 for 1.05 V.
// [R3] regulator_control bit 0 enables the USB regulator at 1.3 V, 0 disables and floats it.
// [R4] Either power-down bit at 1 turns off analog, core and USB regulators unconditionally.
// [R5] With no power-down, analog is on, core follows a low enable pin, USB follows its bit.
// [R6] output_slew_select bit 2 sets clock-out slew, 1 fast, 0 slow, resets to 1, read-write.
// [R7] output_slew_select bit 0 sets memory pin slew, resets to 1; bits 15-3 and 1 read zero.
// [R8] An inhibit bit at 1 disables its pin pulldown, at 0 enables it; all reset to 1.
// [R9] Inhibit bits 13-8 serve serial port 1 pins 5-0, bits 5-0 port 0; 15-14, 7-6 read zero.
// [R10] The test-reset pin pulldown is always enabled and no bit can disable it.
// [R11] Both regulator_control bits reset to 0 and are read-write.
// [R12] Regulator enables and voltage select decode combinationally with no pipeline delay; core_regulator_on lags the pin two clocks through the synchroniser.
`timescale 1ns/1ps
`default_nettype none

module parcr_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [15:0] rdata,
  // Power-down bits from the RTC power management register
  input  wire logic        bandgap_powerdown,
  input  wire logic        regulator_powerdown,
  // External core regulator enable pin, active low
  input  wire logic        core_reg_pin_enable_n,
  // Regulator controls
  output logic             analog_regulator_on,
  output logic             core_regulator_on,
  output logic             usb_regulator_on,
  output logic             usb_regulator_out_hiz,
  output logic             core_reg_volt_sel,
  // Pad controls
  output logic             clock_out_slew_sel,
  output logic             ext_mem_slew_sel,
  output logic      [5:0]  sp1_pd_inhibit,
  output logic      [5:0]  sp0_pd_inhibit,
  output logic      [5:0]  sp1_pd_enable,
  output logic      [5:0]  sp0_pd_enable,
  output logic             test_reset_n_pd_enable
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  parcr_pkg::parcr_state_t st;
  parcr_pkg::parcr_state_t next_st;
  logic                    srst_n;
  logic                    pin_en_n_sync;
  logic                    any_pd;
  logic                    wr_ctl;
  logic                    wr_slew;
  logic                    wr_inh;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Shared by the write and read paths
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Inhibit register image with reserved bits forced low
  function automatic logic [15:0] inhibit_word(input logic [5:0] p1,
                                               input logic [5:0] p0);
    logic [15:0] w;
    w = parcr_pkg::DATA_ZERO;
    w[parcr_pkg::SP1_LSB +: parcr_pkg::SP_PINS] = p1; // R9
    w[parcr_pkg::SP0_LSB +: parcr_pkg::SP_PINS] = p0; // R9
    inhibit_word = w;
  endfunction : inhibit_word

  // ----------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------
  // Release of the async reset is retimed so the bank and pin synchroniser flops leave reset together
  parcr_sync2 #(
    .RST_VAL (1'h0)
  ) u_rst_sync (
    .clk   (clk),
    .rst_n (rstn),
    .d     (1'h1),
    .q     (srst_n)
  );

  // Pin is asynchronous; reset value keeps the core regulator on
  parcr_sync2 #(
    .RST_VAL (1'h0)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (srst_n),
    .d     (core_reg_pin_enable_n),
    .q     (pin_en_n_sync)
  );

  // ----------------------------------------------------------------------
  // Strobes
  // ----------------------------------------------------------------------
  assign wr_ctl  = wr_en && hit(addr, parcr_pkg::OFS_REGCTL);
  assign wr_slew = wr_en && hit(addr, parcr_pkg::OFS_SLEW);
  assign wr_inh  = wr_en && hit(addr, parcr_pkg::OFS_INHIBIT);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Read data is valid only in the cycle after a read; zero otherwise
  always_comb begin
    next_st       = st;
    next_st.rdata = parcr_pkg::DATA_ZERO;
    if (wr_ctl) begin
      // Only the two low bits are stored, upper bits are dropped
      next_st.usb_en   = wdata[parcr_pkg::BIT_USB_EN];   // R1 R3 R11
      next_st.volt_sel = wdata[parcr_pkg::BIT_VOLT_SEL]; // R2 R11
    end
    if (wr_slew) begin
      next_st.clk_slew  = wdata[parcr_pkg::BIT_CLK_SLEW];  // R6
      next_st.emif_slew = wdata[parcr_pkg::BIT_EMIF_SLEW]; // R7
    end
    if (wr_inh) begin
      next_st.sp1_inh = wdata[parcr_pkg::SP1_LSB +: parcr_pkg::SP_PINS]; // R8 R9
      next_st.sp0_inh = wdata[parcr_pkg::SP0_LSB +: parcr_pkg::SP_PINS]; // R8 R9
    end
    if (rd_en) begin
      if (hit(addr, parcr_pkg::OFS_REGCTL)) begin
        next_st.rdata[parcr_pkg::BIT_USB_EN]   = st.usb_en;   // R1
        next_st.rdata[parcr_pkg::BIT_VOLT_SEL] = st.volt_sel; // R1
      end else if (hit(addr, parcr_pkg::OFS_SLEW)) begin
        next_st.rdata[parcr_pkg::BIT_CLK_SLEW]  = st.clk_slew;  // R7
        next_st.rdata[parcr_pkg::BIT_EMIF_SLEW] = st.emif_slew; // R7
      end else if (hit(addr, parcr_pkg::OFS_INHIBIT)) begin
        next_st.rdata = inhibit_word(st.sp1_inh, st.sp0_inh); // R9
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      st.usb_en    <= parcr_pkg::RST_USB_EN;   // R11
      st.volt_sel  <= parcr_pkg::RST_VOLT_SEL; // R11
      st.clk_slew  <= parcr_pkg::RST_SLEW;     // R6
      st.emif_slew <= parcr_pkg::RST_SLEW;     // R7
      st.sp1_inh   <= parcr_pkg::RST_INHIBIT;  // R8
      st.sp0_inh   <= parcr_pkg::RST_INHIBIT;  // R8
      st.rdata     <= parcr_pkg::DATA_ZERO;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Regulator decode
  // ----------------------------------------------------------------------
  // Purely combinational so power-down acts in the same cycle
  assign any_pd                = bandgap_powerdown || regulator_powerdown;   // R4 R12
  assign analog_regulator_on   = !any_pd;                                    // R4 R5
  assign core_regulator_on     = !any_pd && !pin_en_n_sync;                  // R4 R5
  assign usb_regulator_on      = !any_pd && st.usb_en;                       // R3 R4 R5
  assign usb_regulator_out_hiz = !usb_regulator_on;                          // R3
  assign core_reg_volt_sel     = st.volt_sel;                                // R2 R12

  // ----------------------------------------------------------------------
  // Pad controls
  // ----------------------------------------------------------------------
  assign rdata                  = st.rdata;
  assign clock_out_slew_sel     = st.clk_slew;  // R6
  assign ext_mem_slew_sel       = st.emif_slew; // R7
  assign sp1_pd_inhibit         = st.sp1_inh;   // R9
  assign sp0_pd_inhibit         = st.sp0_inh;   // R9
  // No register bit reaches this pad, so its pulldown cannot be lost
  assign test_reset_n_pd_enable = 1'h1;         // R10

  // Per-pin pulldown enables, inverse of the inhibit bits
  for (genvar i = 0; i < parcr_pkg::SP_PINS; i++) begin : g_pd
    assign sp1_pd_enable[i] = !st.sp1_inh[i]; // R8
    assign sp0_pd_enable[i] = !st.sp0_inh[i]; // R8
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!srst_n);

  // Control register reads never show the reserved bits
  ctl_rsvd_zero_a: assert property ( // R1
    rd_en && hit(addr, parcr_pkg::OFS_REGCTL) |=> rdata[15:2] == 14'h0000
  ) else $error("regulator_control reserved bits read nonzero");

  // A control write lands on the voltage select one cycle later
  volt_sel_write_a: assert property ( // R2
    wr_ctl |=> core_reg_volt_sel == $past(wdata[parcr_pkg::BIT_VOLT_SEL])
  ) else $error("voltage select did not follow control write");

  // USB enable write reaches the regulator when no power-down stands
  usb_en_write_a: assert property ( // R3
    wr_ctl ##1 !any_pd |-> usb_regulator_on == $past(wdata[parcr_pkg::BIT_USB_EN])
  ) else $error("usb regulator did not follow its enable bit");

  // Power-down wins over every other control
  powerdown_off_a: assert property ( // R4
    any_pd |-> !analog_regulator_on && !core_regulator_on && !usb_regulator_on
  ) else $error("regulator on during power-down");

  // Normal operation matrix, same cycle
  normal_matrix_a: assert property ( // R5
    !any_pd |-> analog_regulator_on && core_regulator_on == !pin_en_n_sync
                && usb_regulator_on == st.usb_en
  ) else $error("regulator decode wrong without power-down");

  // Pin level takes exactly two edges to reach the core regulator
  pin_latency_a: assert property ( // R12
    !any_pd ##0 $stable(any_pd) [*3] |-> core_regulator_on == !$past(core_reg_pin_enable_n, 2)
  ) else $error("core regulator pin latency wrong");

  // Slew write then readback returns the written bits, reserved low
  slew_readback_a: assert property ( // R6 R7
    wr_slew ##1 (rd_en && hit(addr, parcr_pkg::OFS_SLEW))
    |=> rdata == {13'h0000, $past(wdata[2], 2), 1'h0, $past(wdata[0], 2)}
  ) else $error("slew register readback mismatch");

  // Inhibit readback matches the pin outputs and reserved bits are low
  inhibit_read_a: assert property ( // R8 R9
    rd_en && hit(addr, parcr_pkg::OFS_INHIBIT)
    |=> rdata == {2'h0, sp1_pd_inhibit, 2'h0, sp0_pd_inhibit}
  ) else $error("inhibit register readback mismatch");

  // Enables always mirror the inhibit bits
  pd_enable_map_a: assert property ( // R8
    sp1_pd_enable == ~sp1_pd_inhibit && sp0_pd_enable == ~sp0_pd_inhibit
  ) else $error("pulldown enable does not mirror inhibit");

  // Test-reset pulldown never goes away
  trst_pd_on_a: assert property ( // R10
    test_reset_n_pd_enable
  ) else $error("test reset pulldown disabled");

  // Values right after reset release
  reset_values_a: assert property ( // R11
    $rose(srst_n) |-> !st.usb_en && !st.volt_sel && clock_out_slew_sel
                      && ext_mem_slew_sel && &sp1_pd_inhibit && &sp0_pd_inhibit
  ) else $error("reset values wrong");

  // Reads of unmapped addresses return zero
  unmapped_zero_a: assert property (
    rd_en && !hit(addr, parcr_pkg::OFS_REGCTL) && !hit(addr, parcr_pkg::OFS_SLEW)
    && !hit(addr, parcr_pkg::OFS_INHIBIT) |=> rdata == parcr_pkg::DATA_ZERO
  ) else $error("unmapped read returned nonzero");

  // Main scenarios
  usb_on_c:     cover property (wr_ctl ##1 usb_regulator_on);
  powerdown_c:  cover property (usb_regulator_on ##1 any_pd);
  slew_slow_c:  cover property (wr_slew ##1 !clock_out_slew_sel && !ext_mem_slew_sel);
  pd_enable_c:  cover property (wr_inh ##1 (|sp0_pd_enable));

endmodule : parcr_regs

`default_nettype wire

// ===== parcr_regs_tb.sv
// Self-checking testbench for the pad and regulator configuration register bank
`timescale 1ns/1ps
`default_nettype none

module parcr_regs_tb;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        clk;
  logic        rstn;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] rdata;
  logic        bandgap_powerdown;
  logic        regulator_powerdown;
  logic        core_reg_pin_enable_n;
  logic        analog_regulator_on;
  logic        core_regulator_on;
  logic        usb_regulator_on;
  logic        usb_regulator_out_hiz;
  logic        core_reg_volt_sel;
  logic        clock_out_slew_sel;
  logic        ext_mem_slew_sel;
  logic [5:0]  sp1_pd_inhibit;
  logic [5:0]  sp0_pd_inhibit;
  logic [5:0]  sp1_pd_enable;
  logic [5:0]  sp0_pd_enable;
  logic        test_reset_n_pd_enable;
  logic [15:0] sh_slew;
  logic [15:0] sh_inh;
  logic [15:0] sh_ctl;
  logic [15:0] rd_val;
  logic [15:0] a_tab [4];
  int          fails;
  int          n_checks;
  int          cycles;

  parcr_regs dut_u (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .bandgap_powerdown(bandgap_powerdown),
    .regulator_powerdown(regulator_powerdown), .core_reg_pin_enable_n(core_reg_pin_enable_n),
    .analog_regulator_on(analog_regulator_on), .core_regulator_on(core_regulator_on),
    .usb_regulator_on(usb_regulator_on), .usb_regulator_out_hiz(usb_regulator_out_hiz),
    .core_reg_volt_sel(core_reg_volt_sel), .clock_out_slew_sel(clock_out_slew_sel),
    .ext_mem_slew_sel(ext_mem_slew_sel), .sp1_pd_inhibit(sp1_pd_inhibit),
    .sp0_pd_inhibit(sp0_pd_inhibit), .sp1_pd_enable(sp1_pd_enable),
    .sp0_pd_enable(sp0_pd_enable), .test_reset_n_pd_enable(test_reset_n_pd_enable)
  );

  // ----------------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run is near 700 cycles, so 8000 only trips on a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fails = fails + 1;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // Expectation helpers
  // ----------------------------------------------------------------------
  // Writable bits per address; unmapped places keep nothing
  function automatic logic [15:0] wmask(input logic [15:0] a);
    case (a)
      parcr_pkg::OFS_SLEW:    wmask = 16'h0005;
      parcr_pkg::OFS_INHIBIT: wmask = 16'h3f3f;
      parcr_pkg::OFS_REGCTL:  wmask = 16'h0003;
      default:                wmask = 16'h0000;
    endcase
  endfunction : wmask

  function automatic logic [15:0] shadow_rd(input logic [15:0] a);
    case (a)
      parcr_pkg::OFS_SLEW:    shadow_rd = sh_slew;
      parcr_pkg::OFS_INHIBIT: shadow_rd = sh_inh;
      parcr_pkg::OFS_REGCTL:  shadow_rd = sh_ctl;
      default:                shadow_rd = 16'h0000;
    endcase
  endfunction : shadow_rd

  // Order: analog on, core on, usb on, usb output floating
  function automatic logic [3:0] reg_exp(input logic bg, input logic ldo, input logic usb,
                                         input logic pin);
    logic pd;
    pd = bg | ldo;
    reg_exp = {!pd, !pd && !pin, !pd && usb, !(!pd && usb)};
  endfunction : reg_exp

  // ----------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Leaves the strobe up; the next get_rd or idle drops it one edge later, a following put_wr keeps it up
  task automatic put_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    addr  <= a;
    wdata <= d;
    case (a)
      parcr_pkg::OFS_SLEW:    sh_slew = d & wmask(a);
      parcr_pkg::OFS_INHIBIT: sh_inh  = d & wmask(a);
      parcr_pkg::OFS_REGCTL:  sh_ctl  = d & wmask(a);
      default:                sh_ctl  = sh_ctl;
    endcase
  endtask : put_wr

  task automatic get_rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    wr_en <= 1'b0;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    #1 d = rdata;
  endtask : get_rd

  task automatic idle();
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    #1;
  endtask : idle

  task automatic chk_pads();
    chk({2'h0, sp1_pd_inhibit, 2'h0, sp0_pd_inhibit}, sh_inh);
    chk({2'h0, sp1_pd_enable, 2'h0, sp0_pd_enable}, ~sh_inh & 16'h3f3f);
    chk({13'h0, clock_out_slew_sel, 1'h0, ext_mem_slew_sel}, sh_slew);
    chk({14'h0, core_reg_volt_sel, test_reset_n_pd_enable}, {14'h0, sh_ctl[1], 1'h1});
  endtask : chk_pads

  task automatic chk_regs(input logic bg, input logic ldo, input logic pin);
    chk({12'h0, analog_regulator_on, core_regulator_on, usb_regulator_on,
         usb_regulator_out_hiz}, {12'h0, reg_exp(bg, ldo, sh_ctl[0], pin)});
  endtask : chk_regs

  // Holds reset three cycles, checks reset levels, leaves room for the retimed release
  task automatic do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    sh_slew = 16'h0005;
    sh_inh  = 16'h3f3f;
    sh_ctl  = 16'h0000;
    repeat (3) @(posedge clk);
    // Release on the edge; the retimed copy keeps the bank in reset two more edges
    rstn <= 1'b1;
    #1 chk_pads();
    repeat (2) @(posedge clk);
  endtask : do_reset

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rstn = 1'b0; addr = 16'h0000; wdata = 16'h0000; wr_en = 1'b0; rd_en = 1'b0;
    bandgap_powerdown = 1'b0; regulator_powerdown = 1'b0; core_reg_pin_enable_n = 1'b0;
    fails = 0; n_checks = 0; cycles = 0;
    a_tab[0] = parcr_pkg::OFS_SLEW;
    a_tab[1] = parcr_pkg::OFS_INHIBIT;
    a_tab[2] = parcr_pkg::OFS_REGCTL;
    a_tab[3] = 16'h1c18;
    void'($urandom(44));
    do_reset();
    // Reset values through the bus, then an unmapped read that stands one cycle
    for (int i = 0; i < 4; i++) begin
      get_rd(a_tab[i], rd_val);
      chk(rd_val, shadow_rd(a_tab[i]));
    end
    // A nonzero read first, so the drop back to zero is really seen
    get_rd(a_tab[1], rd_val);
    chk(rd_val, shadow_rd(a_tab[1]));
    @(posedge clk);
    #1 chk(rdata, 16'h0000);
    // All ones then all zeros, each read back to back after its write
    for (int i = 0; i < 4; i++) begin
      for (int v = 0; v < 2; v++) begin
        put_wr(a_tab[i], (v == 0) ? 16'hffff : 16'h0000);
        get_rd(a_tab[i], rd_val);
        chk(rd_val, shadow_rd(a_tab[i]));
        chk_pads();
        chk_regs(1'b0, 1'b0, 1'b0);
      end
    end
    // Random traffic with unmapped addresses mixed in
    for (int n = 0; n < 200; n++) begin
      a_tab[3] = 16'($urandom());
      put_wr(a_tab[$urandom() % 4], 16'($urandom()));
      if ($urandom() % 2 == 1) begin
        get_rd(a_tab[$urandom() % 4], rd_val);
        chk(rd_val, shadow_rd(addr));
      end else begin
        idle();
      end
      chk_pads();
      chk_regs(1'b0, 1'b0, 1'b0);
    end
    // Every combination of the regulator control matrix
    for (int i = 0; i < 16; i++) begin
      put_wr(parcr_pkg::OFS_REGCTL, {14'h0, 1'($urandom()), 1'(i >> 1)});
      idle();
      @(posedge clk);
      core_reg_pin_enable_n <= 1'(i);
      repeat (3) @(posedge clk);
      bandgap_powerdown   <= 1'(i >> 3);
      regulator_powerdown <= 1'(i >> 2);
      #1 chk_regs(1'(i >> 3), 1'(i >> 2), 1'(i));
      chk_pads();
      @(posedge clk);
      bandgap_powerdown   <= 1'b0;
      regulator_powerdown <= 1'b0;
      #1 chk_regs(1'b0, 1'b0, 1'(i));
    end
    @(posedge clk);
    core_reg_pin_enable_n <= 1'b0;
    // Reset in mid-run after changing every register
    put_wr(parcr_pkg::OFS_INHIBIT, 16'h0000);
    put_wr(parcr_pkg::OFS_SLEW, 16'h0000);
    put_wr(parcr_pkg::OFS_REGCTL, 16'h0003);
    idle();
    do_reset();
    for (int i = 0; i < 3; i++) begin
      get_rd(a_tab[i], rd_val);
      chk(rd_val, shadow_rd(a_tab[i]));
    end
    chk_regs(1'b0, 1'b0, 1'b0);
    end_of_test();
  end

endmodule : parcr_regs_tb

`default_nettype wire

// ===== parcr_sync2.sv
// Two flip-flop synchroniser with a constant reset value
`timescale 1ns/1ps
`default_nettype none

module parcr_sync2 #(
  parameter logic RST_VAL = 1'h0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Asynchronous level in, synchronised level out
  input  wire logic d,
  output logic      q
);

  parcr_pkg::parcr_sync_t st;
  parcr_pkg::parcr_sync_t next_st;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // First stage feeds only the second stage
  always_comb begin
    next_st      = st;
    next_st.meta = d;
    next_st.q    = st.meta;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset loads constants only, never the input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= {RST_VAL, RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.q;

endmodule : parcr_sync2

`default_nettype wire
